// ==== include/panel_defs.vh ====
// constants for the cabinet front-panel controller
`ifndef PANEL_DEFS_VH
`define PANEL_DEFS_VH
`define CLK_HZ          250000000
`define TONE_FULL_S     30
`define RING_ON_S       2
`define RING_PERIOD_S   5
`define SILENCE_S       10'h384
`define STEP_MIN        15
// key index positions
`define K_HIDDEN        0
`define K_BLOWER        1
`define K_LIGHT         2
`define K_UV            3
`define K_OUTLET        4
`define K_SILENCE       5
`define K_UP            6
`define K_DOWN          7
// password codes: bit set means blower key at that position
`define PW_NONE         4'h8
`define PW_DEFAULT      4'h5
`endif

// ==== verif/panel_ctrl_props.sv ====
// port checker for the panel controller
`timescale 1ns/1ps
`default_nettype none
`include "panel_defs.vh"
module panel_ctrl_props #(
  parameter SEC_CYCLES = 20,
  parameter DUR_W      = 4
) (
  input wire logic               clk,
  input wire logic               resetn,
  input wire logic [7:0]         key,
  input wire logic               modifier,
  input wire logic [7:0]         alarm_cause,
  input wire logic [4*DUR_W-1:0] nv_dur,
  input wire logic               red_led,
  input wire logic               sounder,
  input wire logic [2:0]         alarm_code,
  input wire logic [3:0]         func_on,
  input wire logic [3:0]         func_led,
  input wire logic               nv_we
);
  // ==========
  // helper state
  // second ticks may lag by one second, hence the slack
  localparam int TONE = (`TONE_FULL_S - 1) * SEC_CYCLES;
  localparam int MUTE = `SILENCE_S * SEC_CYCLES;
  localparam int GAP  = `RING_PERIOD_S * SEC_CYCLES;
  wire logic  alarm = |alarm_cause;
  logic       menu_reg;
  int         run_reg, mute_reg, gap_reg;
  logic [2:0] top;
  always_comb
  begin
    top = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (alarm_cause[i])
        top = 3'(i);
  end
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      menu_reg <= 1'b0;
      run_reg  <= 0;
      mute_reg <= 0;
      gap_reg  <= 0;
    end
    else
    begin
      if ($fell(modifier))
        menu_reg <= 1'b1;
      else if ($rose(key[0]) || $rose(key[5]))
        menu_reg <= 1'b0;
      run_reg <= alarm ? run_reg + 1 : 0;
      if ($rose(key[5]) && !modifier && !menu_reg && alarm)
        mute_reg <= MUTE;
      else if (mute_reg != 0)
        mute_reg <= mute_reg - 1;
      gap_reg <= (alarm && !sounder && mute_reg == 0) ? gap_reg + 1 : 0;
    end
  // ==========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_held; (alarm && $stable(alarm_cause))[*3]; endsequence
  sequence s_idle; (!alarm)[*3]; endsequence
  sequence s_untimed; (func_on[0] && nv_dur[DUR_W-1:0] == 0)[*3]; endsequence
  property p_red; s_held |-> red_led; endproperty
  property p_code; s_held |-> alarm_code == top; endproperty
  property p_quiet; s_idle |-> !sounder; endproperty
  property p_tone;
    run_reg > 3 && run_reg < TONE && mute_reg == 0 |-> sounder;
  endproperty
  property p_ring; gap_reg <= GAP; endproperty
  property p_muted;
    mute_reg > 2 * SEC_CYCLES && mute_reg < MUTE - 2 |-> !sounder;
  endproperty
  property p_toggle;
    $rose(key[4]) && !modifier && !menu_reg |-> ##[1:2] $changed(func_on[0]);
  endproperty
  property p_steady; s_untimed |-> func_led[0]; endproperty
  property p_commit;
    $rose(key[0]) && !modifier && menu_reg |-> ##[1:3] nv_we;
  endproperty
  property p_abort; $rose(key[5]) && menu_reg |-> (!nv_we)[*6]; endproperty
  property p_pulse; nv_we |=> !nv_we; endproperty
  a_red: assert property (p_red)
    else $error("red indicator off during alarm");
  a_code: assert property (p_code)
    else $error("reported cause is not the highest");
  a_quiet: assert property (p_quiet)
    else $error("sounder on without alarm");
  a_tone: assert property (p_tone)
    else $error("sounder gap in continuous tone");
  a_ring: assert property (p_ring)
    else $error("ring-back gap too long");
  a_muted: assert property (p_muted)
    else $error("sounder on while silenced");
  a_toggle: assert property (p_toggle)
    else $error("outlet did not toggle");
  a_steady: assert property (p_steady)
    else $error("untimed outlet indicator not steady");
  a_commit: assert property (p_commit)
    else $error("no store pulse on accept");
  a_abort: assert property (p_abort)
    else $error("store pulse after abort");
  a_pulse: assert property (p_pulse)
    else $error("store pulse longer than one cycle");
endmodule // panel_ctrl_props
bind panel_ctrl panel_ctrl_props #(
  .SEC_CYCLES(SEC_CYCLES),
  .DUR_W(DUR_W)
) i_panel_ctrl_props (
  .clk(clk), .resetn(resetn), .key(key), .modifier(modifier),
  .alarm_cause(alarm_cause), .nv_dur(nv_dur), .red_led(red_led),
  .sounder(sounder), .alarm_code(alarm_code), .func_on(func_on),
  .func_led(func_led), .nv_we(nv_we)
);
`default_nettype wire

// ==== verif/panel_ctrl_test.sv ====
// self-checking bench for the panel controller
`timescale 1ns/1ps
`default_nettype none
`include "panel_defs.vh"
module panel_ctrl_test;
  localparam int SEC = 20;
  logic        clk, resetn, pw_mandatory, modifier;
  logic        red_led, sounder, blower_red_led, nv_we;
  logic [7:0]  key, alarm_cause;
  logic [2:0]  alarm_code;
  logic [3:0]  func_on, func_led, nv_pw, nv_pw_out, seg_value;
  logic [15:0] nv_dur, nv_dur_out;
  logic [19:0] exp_q[$];
  int          n_mismatch, tests_run, ones, flips;
  wire logic [4:0] mon = {sounder, red_led, blower_red_led, func_led[1:0]};
  panel_ctrl #(.SEC_CYCLES(SEC), .DUR_W(4)) i_panel_ctrl (
    .clk(clk), .resetn(resetn), .key(key), .modifier(modifier),
    .alarm_cause(alarm_cause), .pw_mandatory(pw_mandatory),
    .nv_dur(nv_dur), .nv_pw(nv_pw), .red_led(red_led),
    .sounder(sounder), .alarm_code(alarm_code), .func_on(func_on),
    .func_led(func_led), .blower_red_led(blower_red_led),
    .seg_value(seg_value), .nv_we(nv_we), .nv_dur_out(nv_dur_out),
    .nv_pw_out(nv_pw_out)
  );
  panel_operator i_panel_operator (
    .clk(clk), .nv_we(nv_we), .nv_dur_out(nv_dur_out),
    .nv_pw_out(nv_pw_out), .key(key), .modifier(modifier),
    .nv_dur(nv_dur), .nv_pw(nv_pw)
  );
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ones and changes of one indicator over n cycles
  task automatic watch(input int sel, input int n);
    logic last;
    ones = 0;
    flips = 0;
    last = mon[sel];
    repeat (n)
    begin
      @(negedge clk);
      ones += int'(mon[sel]);
      flips += int'(mon[sel] != last);
      last = mon[sel];
    end
  endtask
  task automatic give_verdict;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========
  // commit monitor
  always @(posedge clk)
    if (resetn && nv_we)
    begin
      if (exp_q.size() == 0)
        check(20'h0, 20'hfffff);
      else
        check({nv_dur_out, nv_pw_out}, exp_q.pop_front());
    end
  initial
  begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    give_verdict;
  end
  // ==========
  // scenarios
  initial
  begin
    resetn = 1'b0;
    alarm_cause = 8'h00;
    pw_mandatory = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    ones = $urandom(32'h9b3ed0d0);
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    watch(3, 80);
    check(20'(flips > 0), 20'h1);
    i_panel_operator.press(`K_UP);
    watch(3, 80);
    check(20'(ones), 20'h0);
    i_panel_operator.press(`K_OUTLET);
    watch(0, 80);
    check(20'({func_on, 8'(ones)}), 20'h150);
    i_panel_operator.press(`K_OUTLET);
    i_panel_operator.menu(`K_HIDDEN, `K_OUTLET, `K_OUTLET);
    watch(0, 80);
    check(20'(flips > 2), 20'h1);
    repeat (3) i_panel_operator.press(`K_UP);
    i_panel_operator.press(`K_DOWN);
    check(20'(seg_value), 20'h2);
    exp_q.push_back({16'h0002, 4'h8});
    i_panel_operator.press(`K_HIDDEN);
    i_panel_operator.menu(`K_HIDDEN, `K_LIGHT, `K_LIGHT);
    watch(1, 80);
    check(20'(flips > 2), 20'h1);
    repeat (3) i_panel_operator.press(`K_UP);
    check(20'(seg_value), 20'h3);
    i_panel_operator.press(`K_SILENCE);
    check(20'(nv_dur), 20'h2);
    i_panel_operator.press(`K_OUTLET);
    watch(0, 80);
    check(20'(flips > 1), 20'h1);
    repeat (34500) @(posedge clk);
    check(20'(func_on[0]), 20'h1);
    repeat (2800) @(posedge clk);
    check(20'(func_on[0]), 20'h0);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      alarm_cause <= (8'h01 << i) | (8'($urandom) & ~((8'h02 << i) - 8'h01));
      repeat (5) @(posedge clk);
      check(20'({red_led, alarm_code}), 20'(8 + i));
    end
    watch(4, 400);
    check(20'(ones), 20'd400);
    repeat (300) @(posedge clk);
    watch(4, 200);
    check(20'(flips > 2 && ones >= 60 && ones <= 100), 20'h1);
    i_panel_operator.press(`K_SILENCE);
    watch(4, 17000);
    check(20'(ones), 20'h0);
    watch(4, 1600);
    check(20'(ones > 0), 20'h1);
    @(posedge clk);
    alarm_cause <= 8'h00;
    repeat (5) @(posedge clk);
    check(20'({red_led, sounder}), 20'h0);
    i_panel_operator.menu(`K_HIDDEN, `K_BLOWER, `K_HIDDEN);
    watch(2, 80);
    check(20'(flips > 2), 20'h1);
    for (int i = 0; i < 9 && seg_value !== 4'h5; i++)
      i_panel_operator.press(`K_UP);
    check(20'(seg_value), 20'h5);
    exp_q.push_back({16'h0002, 4'h5});
    i_panel_operator.press(`K_HIDDEN);
    i_panel_operator.press(`K_BLOWER);
    i_panel_operator.press(`K_HIDDEN);
    check(20'(func_on[3]), 20'h0);
    i_panel_operator.press(`K_BLOWER);
    check(20'(func_on[3]), 20'h1);
    pw_mandatory <= 1'b1;
    i_panel_operator.menu(`K_HIDDEN, `K_BLOWER, `K_HIDDEN);
    repeat (9)
    begin
      i_panel_operator.press(`K_UP);
      check(20'(seg_value == 4'h8), 20'h0);
    end
    i_panel_operator.press(`K_SILENCE);
    repeat (20) @(posedge clk);
    check(20'(exp_q.size()), 20'h0);
    give_verdict;
  end
endmodule // panel_ctrl_test
`default_nettype wire

// ==== verif/panel_operator.sv ====
// operator and parameter store model for the panel
`timescale 1ns/1ps
`default_nettype none
module panel_operator (
  input  wire logic        clk,
  input  wire logic        nv_we,
  input  wire logic [15:0] nv_dur_out,
  input  wire logic [3:0]  nv_pw_out,
  output var  logic [7:0]  key,
  output var  logic        modifier,
  output var  logic [15:0] nv_dur,
  output var  logic [3:0]  nv_pw
);
  initial
  begin
    key = 8'h00;
    modifier = 1'b0;
    nv_dur = 16'h0000;
    nv_pw = 4'h8;
  end
  always @(posedge clk)
    if (nv_we)
    begin
      nv_dur <= nv_dur_out;
      nv_pw <= nv_pw_out;
    end
  // one key at a time, held two cycles
  task automatic press(input int k);
    @(posedge clk);
    key[k] <= 1'b1;
    repeat (2) @(posedge clk);
    key[k] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic menu(input int a, input int b, input int c);
    @(posedge clk);
    modifier <= 1'b1;
    press(a);
    press(b);
    press(c);
    modifier <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule // panel_operator
`default_nettype wire

// ==== verilog/panel_ctrl.v ====
// cabinet front-panel alarm, menu and auto-off timer controller
`timescale 1ns/1ps
`default_nettype none
`include "panel_defs.vh"
module panel_ctrl #(
  parameter SEC_CYCLES = `CLK_HZ,
  parameter DUR_W      = 4
) (
  input  wire              clk,
  input  wire              resetn,
  input  wire [7:0]        key,
  input  wire              modifier,
  input  wire [7:0]        alarm_cause,
  input  wire              pw_mandatory,
  input  wire [4*DUR_W-1:0] nv_dur,
  input  wire [3:0]        nv_pw,
  output reg               red_led,
  output reg               sounder,
  output reg  [2:0]        alarm_code,
  output reg  [3:0]        func_on,
  output reg  [3:0]        func_led,
  output reg               blower_red_led,
  output reg  [DUR_W-1:0]  seg_value,
  output reg               nv_we,
  output reg  [4*DUR_W-1:0] nv_dur_out,
  output reg  [3:0]        nv_pw_out
);
  // function index: 0 outlet, 1 light, 2 uv, 3 blower night
  // sized so the countdown load keeps the counter's width
  localparam [DUR_W+9:0] MIN_SECS = 60 * `STEP_MIN;
  localparam ST_IDLE = 4'b0001;
  localparam ST_SEQ  = 4'b0010;
  localparam ST_TMR  = 4'b0100;
  localparam ST_PW   = 4'b1000;

  // ==========================================================
  // key edges and timebase
  reg  [7:0]  key_q_reg;
  wire [7:0]  press = key & ~key_q_reg;
  wire        any_press = |press;
  reg  [31:0] div_reg;
  wire        sec_tick = (div_reg == SEC_CYCLES - 1);
  reg  [2:0]  fast_reg;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      key_q_reg <= 8'h00;
      div_reg   <= 32'h0;
      fast_reg  <= 3'h0;
    end
    else
    begin
      key_q_reg <= key;
      div_reg   <= sec_tick ? 32'h0 : div_reg + 32'h1;
      if (sec_tick)
        fast_reg <= fast_reg + 3'h1;
    end
  end
  // fast blink toggles each second, slow blink every two seconds
  wire blink_slow = fast_reg[1];
  wire blink_fast = fast_reg[0];

  function [2:0] key_idx;
    input [7:0] k;
    begin
      key_idx = k[`K_BLOWER] ? 3'd1 : k[`K_LIGHT] ? 3'd2 :
                k[`K_UV] ? 3'd3 : k[`K_OUTLET] ? 3'd4 : 3'd0;
    end
  endfunction

  function [1:0] func_of;
    input [2:0] i;
    begin
      case (i)
        3'd4:    func_of = 2'd0;
        3'd2:    func_of = 2'd1;
        3'd3:    func_of = 2'd2;
        default: func_of = 2'd3;
      endcase
    end
  endfunction

  // ==========================================================
  // alarm priority and sounder cadence
  // ranking lowest index highest
  reg [2:0] top_cause;
  integer   i;
  always @*
  begin
    top_cause = 3'd0;
    for (i = 7; i >= 0; i = i - 1)
      if (alarm_cause[i])
        top_cause = i[2:0];
  end
  wire alarm_any = |alarm_cause;

  // menu state is read here, so it is declared ahead of the sequencer
  reg [3:0]  state_reg;
  reg        pwr_ack_reg;
  reg [9:0]  tone_sec_reg;
  reg [2:0]  ring_sec_reg;
  reg [9:0]  mute_sec_reg;
  reg        ringback_reg;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pwr_ack_reg  <= 1'b0;
      tone_sec_reg <= 10'h0;
      ring_sec_reg <= 3'h0;
      mute_sec_reg <= 10'h0;
      ringback_reg <= 1'b0;
      red_led      <= 1'b0;
      sounder      <= 1'b0;
      alarm_code   <= 3'h0;
    end
    else
    begin
      if (any_press)
        pwr_ack_reg <= 1'b1;
      alarm_code <= top_cause;
      red_led <= alarm_any | (!pwr_ack_reg & blink_slow);
      if (!alarm_any)
      begin
        tone_sec_reg <= 10'h0;
        ring_sec_reg <= 3'h0;
        mute_sec_reg <= 10'h0;
        ringback_reg <= 1'b0;
      end
      else if (press[`K_SILENCE] && state_reg == ST_IDLE)
      begin
        mute_sec_reg <= `SILENCE_S;
        ringback_reg <= 1'b1;
        ring_sec_reg <= 3'h0;
      end
      else if (sec_tick)
      begin
        if (mute_sec_reg != 10'h0)
          mute_sec_reg <= mute_sec_reg - 10'h1;
        else if (!ringback_reg)
        begin
          if (tone_sec_reg == `TONE_FULL_S - 1)
            ringback_reg <= 1'b1;
          tone_sec_reg <= tone_sec_reg + 10'h1;
        end
        else
          ring_sec_reg <= (ring_sec_reg == `RING_PERIOD_S - 1) ? 3'h0
                          : ring_sec_reg + 3'h1;
      end
      sounder <= alarm_any && mute_sec_reg == 10'h0 &&
                 (!ringback_reg || ring_sec_reg < `RING_ON_S);
    end
  end

  // ==========================================================
  // menu sequencer and settings
  reg [8:0]         seq_reg;
  reg [1:0]         seq_cnt_reg;
  reg [1:0]         sel_reg;
  reg [4*DUR_W-1:0] dur_reg;
  reg [DUR_W-1:0]   edit_reg;
  reg [3:0]         pw_reg;
  reg [3:0]         pw_edit_reg;
  reg [2:0]         pw_in_reg;
  reg [1:0]         pw_cnt_reg;
  reg               boot_reg;
  reg [3:0]         next_code;
  reg [3:0]         prev_code;
  always @*
  begin
    // cycle 0..7 plus none unless mandatory
    next_code = (pw_edit_reg == `PW_NONE) ? 4'h0 :
                (pw_edit_reg == 4'h7) ? (pw_mandatory ? 4'h0 : `PW_NONE)
                : pw_edit_reg + 4'h1;
    prev_code = (pw_edit_reg == `PW_NONE) ? 4'h7 :
                (pw_edit_reg == 4'h0) ? (pw_mandatory ? 4'h7 : `PW_NONE)
                : pw_edit_reg - 4'h1;
  end
  wire pw_active = pw_mandatory || pw_reg != `PW_NONE;

  reg [DUR_W+9:0] left_reg [0:3];
  reg [3:0]       timing_reg;
  integer f;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg   <= ST_IDLE;
      seq_reg     <= 9'h0;
      seq_cnt_reg <= 2'h0;
      sel_reg     <= 2'h0;
      dur_reg     <= {4*DUR_W{1'b0}};
      edit_reg    <= {DUR_W{1'b0}};
      pw_reg      <= `PW_NONE;
      pw_edit_reg <= `PW_NONE;
      pw_in_reg   <= 3'h0;
      pw_cnt_reg  <= 2'h0;
      boot_reg    <= 1'b1;
      func_on     <= 4'h0;
      timing_reg  <= 4'h0;
      nv_we       <= 1'b0;
      nv_dur_out  <= {4*DUR_W{1'b0}};
      nv_pw_out   <= `PW_NONE;
      for (f = 0; f < 4; f = f + 1)
        left_reg[f] <= {DUR_W+10{1'b0}};
    end
    else
    begin
      nv_we <= 1'b0;
      // restore stored settings after reset release
      if (boot_reg)
      begin
        boot_reg <= 1'b0;
        dur_reg  <= nv_dur;
        pw_reg   <= (pw_mandatory && nv_pw == `PW_NONE) ? `PW_DEFAULT
                    : nv_pw;
      end
      case (state_reg)
        ST_IDLE:
        begin
          if (modifier && !any_press)
          begin
            state_reg   <= ST_SEQ;
            seq_cnt_reg <= 2'h0;
          end
          else if (any_press && !modifier)
          begin
            if (press[`K_BLOWER] || press[`K_HIDDEN])
            begin
              if (pw_active)
              begin
                pw_in_reg  <= {pw_in_reg[1:0], press[`K_BLOWER]};
                pw_cnt_reg <= (pw_cnt_reg == 2'd2) ? 2'd0
                              : pw_cnt_reg + 2'd1;
                if (pw_cnt_reg == 2'd2 &&
                    {pw_in_reg[1:0], press[`K_BLOWER]} == pw_reg[2:0])
                  func_on[3] <= ~func_on[3];
              end
              else if (press[`K_BLOWER])
                func_on[3] <= ~func_on[3];
            end
            for (f = 0; f < 3; f = f + 1)
              if (press[key_idx(press)] && func_of(key_idx(press)) == f
                  && !press[`K_BLOWER] && !press[`K_HIDDEN])
                func_on[f] <= ~func_on[f];
          end
        end
        ST_SEQ:
        begin
          if (any_press && seq_cnt_reg != 2'd3)
          begin
            seq_reg     <= {seq_reg[5:0], key_idx(press)};
            seq_cnt_reg <= seq_cnt_reg + 2'd1;
          end
          if (!modifier)
          begin
            state_reg <= ST_IDLE;
            if (seq_cnt_reg == 2'd3 && seq_reg[8:6] == 3'd0)
            begin
              if (seq_reg[5:3] == 3'd1 && seq_reg[2:0] == 3'd0)
              begin
                state_reg   <= ST_PW;
                pw_edit_reg <= pw_reg;
              end
              else if (seq_reg[5:3] == seq_reg[2:0] &&
                       seq_reg[2:0] != 3'd0)
              begin
                state_reg <= ST_TMR;
                sel_reg   <= func_of(seq_reg[2:0]);
                edit_reg  <= dur_reg[func_of(seq_reg[2:0])*DUR_W +: DUR_W];
              end
            end
          end
        end
        ST_TMR:
        begin
          if (press[`K_UP] && edit_reg != {DUR_W{1'b1}})
            edit_reg <= edit_reg + 1'b1;
          else if (press[`K_DOWN] && edit_reg != {DUR_W{1'b0}})
            edit_reg <= edit_reg - 1'b1;
          if (press[`K_SILENCE])
            state_reg <= ST_IDLE;
          else if (press[`K_HIDDEN])
          begin
            state_reg <= ST_IDLE;
            dur_reg[sel_reg*DUR_W +: DUR_W] <= edit_reg;
            nv_dur_out <= dur_reg;
            nv_dur_out[sel_reg*DUR_W +: DUR_W] <= edit_reg;
            nv_pw_out  <= pw_reg;
            nv_we      <= 1'b1;
          end
        end
        ST_PW:
        begin
          if (press[`K_UP])
            pw_edit_reg <= next_code;
          else if (press[`K_DOWN])
            pw_edit_reg <= prev_code;
          if (press[`K_SILENCE])
            state_reg <= ST_IDLE;
          else if (press[`K_HIDDEN])
          begin
            state_reg  <= ST_IDLE;
            pw_reg     <= pw_edit_reg;
            nv_pw_out  <= pw_edit_reg;
            nv_dur_out <= dur_reg;
            nv_we      <= 1'b1;
            pw_cnt_reg <= 2'h0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // ======================================================
      // auto-off countdown per function
      for (f = 0; f < 4; f = f + 1)
      begin
        if (!func_on[f])
          timing_reg[f] <= 1'b0;
        else if (!timing_reg[f] && left_reg[f] == 0 &&
                 dur_reg[f*DUR_W +: DUR_W] != 0 && !boot_reg)
        begin
          timing_reg[f] <= 1'b1;
          left_reg[f] <= dur_reg[f*DUR_W +: DUR_W] * MIN_SECS;
        end
        else if (timing_reg[f] && sec_tick)
        begin
          if (left_reg[f] == 1)
          begin
            func_on[f]    <= 1'b0;
            timing_reg[f] <= 1'b0;
          end
          left_reg[f] <= left_reg[f] - 1'b1;
        end
        if (!func_on[f] && !timing_reg[f])
          left_reg[f] <= {DUR_W+10{1'b0}};
      end
    end
  end

  // ==========================================================
  // indicators
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      func_led       <= 4'h0;
      blower_red_led <= 1'b0;
      seg_value      <= {DUR_W{1'b0}};
    end
    else
    begin
      for (f = 0; f < 4; f = f + 1)
        // fast blink when selected; blink when timing
        if (state_reg == ST_TMR && sel_reg == f)
          func_led[f] <= blink_fast;
        else
          func_led[f] <= func_on[f] & (!timing_reg[f] | blink_slow);
      // blower red blinks fast in password menu
      blower_red_led <= (state_reg == ST_PW) & blink_fast;
      seg_value <= (state_reg == ST_PW) ? pw_edit_reg[DUR_W-1:0] : edit_reg;
    end
  end
endmodule // panel_ctrl
`default_nettype wire
